// ---- src/cism_top.sv ----
/*
 * Control I/O state monitor: input polarity and anti-chatter filter,
 * output stability timer and logic inversion, four monitor views and
 * a single-function view captured into snapshot registers over APB.
 * Assumes: one 250 MHz clock, synchronous active-high reset, pins
 * asynchronous, output conditions from logic on the same clock.
 */
`include "cism_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module cism_top #(
    parameter int N_IN    = 17,
    parameter int N_OUT   = 8,
    parameter int N_OFUNC = 10,
    parameter int TW      = 8
) (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [N_IN-1:0]    control_in_pin,
    input  wire logic [N_OFUNC-1:0] out_func_cond,
    output logic      [N_OUT-1:0]   control_out_pin,
    output logic      [15:0]        in_func_state
);
    // refuse sizes the views cannot carry
    if (N_IN < 17 || N_IN > 32 || N_OUT > N_OFUNC || N_OFUNC > 16 || TW < 1)
        $error("cism_top: unsupported size parameters");

    localparam int TICKW = 16;
    localparam logic [TICKW-1:0] TICK_LAST = TICKW'(`CISM_TICK_CYC - 1);

    // pin synchroniser, first stage read only by second
    logic [N_IN-1:0] sync1_reg;
    logic [N_IN-1:0] sync2_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= control_in_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // filter time base
    logic [TICKW-1:0] tick_cnt_reg;
    logic [TICKW-1:0] tick_cnt_next;
    logic             tick;
    always_comb begin
        tick          = (tick_cnt_reg == TICK_LAST);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    end
    always_ff @(posedge clock) begin
        if (reset) tick_cnt_reg <= '0;
        else tick_cnt_reg <= tick_cnt_next;
    end

    // software settings
    logic [N_IN-1:0]  pol_reg, pol_next;
    logic [TW-1:0]    chat_reg, chat_next;
    logic [TW-1:0]    stab_reg, stab_next;
    logic [N_OUT-1:0] inv_reg, inv_next;
    logic [1:0]       view_reg, view_next;
    logic [4:0]       code_reg, code_next;
    logic             wr_en;
    logic             rd_setup;
    logic             hit;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    // polarity applied before filtering
    logic [N_IN-1:0] pol_in;
    assign pol_in = sync2_reg ^ pol_reg;

    // per-input anti-chatter filter
    logic [TW-1:0] icnt_reg  [N_IN];
    logic [TW-1:0] icnt_next [N_IN];
    logic          ifil_reg  [N_IN];
    logic          ifil_next [N_IN];
    logic [N_IN-1:0] filt_vec;
    for (genvar i = 0; i < N_IN; i++) begin : g_in
        always_comb begin
            icnt_next[i] = '0;
            ifil_next[i] = ifil_reg[i];
            if (pol_in[i] != ifil_reg[i]) begin
                if (icnt_reg[i] >= chat_reg) begin
                    ifil_next[i] = pol_in[i];
                end else if (tick) begin
                    icnt_next[i] = icnt_reg[i] + 1'b1;
                end else begin
                    icnt_next[i] = icnt_reg[i];
                end
            end
        end
        always_ff @(posedge clock) begin
            if (reset) begin
                icnt_reg[i] <= '0;
                ifil_reg[i] <= 1'b0;
            end else begin
                icnt_reg[i] <= icnt_next[i];
                ifil_reg[i] <= ifil_next[i];
            end
        end
        assign filt_vec[i] = ifil_reg[i];
    end
    assign in_func_state = filt_vec[15:0];

    // per-output stability timer, then logic inversion to pins
    logic [TW-1:0] ocnt_reg  [N_OUT];
    logic [TW-1:0] ocnt_next [N_OUT];
    logic          ostb_reg  [N_OUT];
    logic          ostb_next [N_OUT];
    logic [N_OUT-1:0] stab_vec;
    for (genvar j = 0; j < N_OUT; j++) begin : g_out
        always_comb begin
            ocnt_next[j] = '0;
            ostb_next[j] = ostb_reg[j];
            if (out_func_cond[j] != ostb_reg[j]) begin
                if (ocnt_reg[j] >= stab_reg) begin
                    ostb_next[j] = out_func_cond[j];
                end else if (tick) begin
                    ocnt_next[j] = ocnt_reg[j] + 1'b1;
                end else begin
                    ocnt_next[j] = ocnt_reg[j];
                end
            end
        end
        always_ff @(posedge clock) begin
            if (reset) begin
                ocnt_reg[j] <= '0;
                ostb_reg[j] <= 1'b0;
            end else begin
                ocnt_reg[j] <= ocnt_next[j];
                ostb_reg[j] <= ostb_next[j];
            end
        end
        assign stab_vec[j] = ostb_reg[j];
    end
    always_ff @(posedge clock) begin
        if (reset) control_out_pin <= '0;
        else control_out_pin <= stab_vec ^ inv_reg;
    end

    // view multiplexer, every bit from the same cycle
    logic [15:0] ofn_ext;
    logic [31:0] view_in;
    logic [31:0] view_out;
    logic        single_bit;
    assign ofn_ext = 16'(out_func_cond);
    always_comb begin
        view_in  = 32'h0000_0000;
        view_out = 32'h0000_0000;
        case (cism_pkg::cism_view_t'(view_reg))
            cism_pkg::CISM_VIEW_RAW: begin
                view_in[N_IN-1:0]   = sync2_reg;
                view_out[N_OUT-1:0] = control_out_pin;
            end
            cism_pkg::CISM_VIEW_FILT: begin
                view_in[N_IN-1:0]   = filt_vec;
                view_out[N_OUT-1:0] = stab_vec;
            end
            cism_pkg::CISM_VIEW_IFN: view_in[15:0] = filt_vec[15:0];
            default: view_out[15:0] = ofn_ext;
        endcase
        // single function: inputs conditioned, outputs before timer
        single_bit = code_reg[4] ? ofn_ext[code_reg[3:0]] : filt_vec[code_reg[3:0]];
    end

    // monitor sequencer and snapshot registers
    cism_pkg::cism_state_t st_reg, st_next;
    logic [31:0] snap_in_reg, snap_in_next;
    logic [31:0] snap_out_reg, snap_out_next;
    logic        valid_reg, valid_next;
    logic        cmd_wr, go_rep, go_one, abort, rep_only;
    assign cmd_wr = wr_en && (paddr == `CISM_CMD_OFS);
    assign rep_only = go_rep && !go_one && !abort; // repeat start not overridden
    assign go_rep = cmd_wr && pwdata[`CISM_CMD_REPEAT_BIT];
    assign go_one = cmd_wr && pwdata[`CISM_CMD_SINGLE_BIT];
    assign abort  = cmd_wr && pwdata[`CISM_CMD_ABORT_BIT];
    always_comb begin
        st_next       = st_reg;
        snap_in_next  = snap_in_reg;
        snap_out_next = snap_out_reg;
        valid_next    = valid_reg;
        if (abort) begin
            st_next = cism_pkg::CISM_ST_PROMPT;
        end else if (go_one) begin
            st_next       = cism_pkg::CISM_ST_PROMPT;
            snap_in_next  = {31'h0000_0000, single_bit};
            snap_out_next = 32'h0000_0000;
            valid_next    = 1'b1;
        end else if (go_rep || (st_reg == cism_pkg::CISM_ST_REFRESH && tick)) begin
            st_next       = cism_pkg::CISM_ST_REFRESH;
            snap_in_next  = view_in;
            snap_out_next = view_out;
            valid_next    = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg       <= cism_pkg::CISM_ST_PROMPT;
            snap_in_reg  <= 32'h0000_0000;
            snap_out_reg <= 32'h0000_0000;
            valid_reg    <= 1'b0;
        end else begin
            st_reg       <= st_next;
            snap_in_reg  <= snap_in_next;
            snap_out_reg <= snap_out_next;
            valid_reg    <= valid_next;
        end
    end

    // setting register writes
    always_comb begin
        pol_next  = pol_reg;
        chat_next = chat_reg;
        stab_next = stab_reg;
        inv_next  = inv_reg;
        view_next = view_reg;
        code_next = code_reg;
        if (wr_en && paddr == `CISM_CTRL_OFS) begin
            view_next = pwdata[`CISM_CTRL_VIEW_MSB:`CISM_CTRL_VIEW_LSB];
            code_next = pwdata[`CISM_CTRL_CODE_MSB:`CISM_CTRL_CODE_LSB];
        end else if (wr_en && paddr == `CISM_POL_OFS) begin
            pol_next = pwdata[N_IN-1:0];
        end else if (wr_en && paddr == `CISM_CHAT_OFS) begin
            chat_next = pwdata[TW-1:0];
        end else if (wr_en && paddr == `CISM_STAB_OFS) begin
            stab_next = pwdata[TW-1:0];
        end else if (wr_en && paddr == `CISM_INV_OFS) begin
            inv_next = pwdata[N_OUT-1:0];
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            pol_reg  <= N_IN'(`CISM_POL_RESET);
            chat_reg <= TW'(`CISM_CHAT_RESET);
            stab_reg <= TW'(`CISM_STAB_RESET);
            inv_reg  <= N_OUT'(`CISM_INV_RESET);
            view_reg <= 2'h0;
            code_reg <= 5'h00;
        end else begin
            pol_reg  <= pol_next;
            chat_reg <= chat_next;
            stab_reg <= stab_next;
            inv_reg  <= inv_next;
            view_reg <= view_next;
            code_reg <= code_next;
        end
    end

    // read data prepared in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        if (paddr == `CISM_CTRL_OFS) begin
            rd_mux[`CISM_CTRL_VIEW_MSB:`CISM_CTRL_VIEW_LSB] = view_reg;
            rd_mux[`CISM_CTRL_CODE_MSB:`CISM_CTRL_CODE_LSB] = code_reg;
        end else if (paddr == `CISM_CMD_OFS) begin
            rd_mux = 32'h0000_0000;
        end else if (paddr == `CISM_STATUS_OFS) begin
            rd_mux[0] = (st_reg == cism_pkg::CISM_ST_REFRESH);
            rd_mux[1] = valid_reg;
        end else if (paddr == `CISM_SNAP_IN_OFS) begin
            rd_mux = snap_in_reg;
        end else if (paddr == `CISM_SNAP_OUT_OFS) begin
            rd_mux = snap_out_reg;
        end else if (paddr == `CISM_POL_OFS) begin
            rd_mux[N_IN-1:0] = pol_reg;
        end else if (paddr == `CISM_CHAT_OFS) begin
            rd_mux[TW-1:0] = chat_reg;
        end else if (paddr == `CISM_STAB_OFS) begin
            rd_mux[TW-1:0] = stab_reg;
        end else if (paddr == `CISM_INV_OFS) begin
            rd_mux[N_OUT-1:0] = inv_reg;
        end else begin
            hit = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) prdata <= 32'h0000_0000;
        else if (rd_setup) prdata <= rd_mux;
    end
    assign pready  = 1'b1; // zero wait states
    assign pslverr = psel && penable && !hit;

    // checks
    a_raw_in_view: assert property (@(posedge clock) disable iff (reset)
        rep_only && view_reg == 2'h0 |=> snap_in_reg[N_IN-1:0] == $past(sync2_reg))
        else $error("raw view not captured from pins");
    a_out_row_hi: assert property (@(posedge clock) disable iff (reset)
        rep_only && view_reg < 2'h2 |=> snap_out_reg[31:N_OUT] == '0)
        else $error("output row above bit 7 not zero");
    a_filt_toward_pol: assert property (@(posedge clock) disable iff (reset)
        ((filt_vec ^ $past(filt_vec)) & (filt_vec ^ $past(pol_in))) == '0)
        else $error("filtered input moved against polarity");
    a_emergency_stop_in_default: assert property (@(posedge clock) disable iff (reset)
        $past(reset) |-> pol_reg[0] == 1'b1)
        else $error("emergency stop not normally closed at reset");
    a_pin_invert: assert property (@(posedge clock) disable iff (reset)
        !$past(reset) |-> control_out_pin == $past(stab_vec ^ inv_reg))
        else $error("output pin not stable value with inversion");
    a_ifn_run_bit: assert property (@(posedge clock) disable iff (reset)
        rep_only && view_reg == 2'h2 |=> snap_in_reg[5] == $past(filt_vec[5]))
        else $error("program start bit wrong in function view");
    a_ofn_view: assert property (@(posedge clock) disable iff (reset)
        rep_only && view_reg == 2'h3 |=> snap_out_reg[15:0] == $past(ofn_ext))
        else $error("output function view not raw conditions");
    a_single_func: assert property (@(posedge clock) disable iff (reset)
        go_one && !abort |=> snap_in_reg == {31'h0000_0000, $past(single_bit)})
        else $error("single function snapshot wrong");
    a_abort_stop: assert property (@(posedge clock) disable iff (reset)
        abort |=> st_reg == cism_pkg::CISM_ST_PROMPT ##1 $stable(snap_in_reg))
        else $error("refresh continued after abort");
    a_in_reserved: assert property (@(posedge clock) disable iff (reset)
        snap_in_reg[31:N_IN] == '0)
        else $error("reserved input view bits not zero");

endmodule

`default_nettype wire

// ---- pkg/cism_defines.svh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * of the control I/O state monitor.
 * Assumes: included by bare name; APB byte addresses, 32-bit words.
 */
// Functional notes
// - raw view shows pin levels, unconditioned
// - inputs bits 0..16, outputs bits 0..7
// - filtered inputs after polarity and anti-chatter
// - filtered outputs after stability timer
// - filtered outputs exclude output logic inversion
// - inverted input reads opposite of raw
// - emergency stop default normally closed contact
// - emergency stop off while input on
// - input function view is conditioned vector
// - input function bit 1 when asserted
// - program start function sits at bit 5
// - output function view before output inversion
// - output function view excludes stability timer
// - output function bit 1 when detected
// - single function request returns one state
// - repeat readout runs until backspace abort; the code also ends it on a single-function request
`ifndef CISM_DEFINES_SVH
`define CISM_DEFINES_SVH

// register byte offsets
`define CISM_CTRL_OFS     8'h00
`define CISM_CMD_OFS      8'h04
`define CISM_STATUS_OFS   8'h08
`define CISM_SNAP_IN_OFS  8'h0C
`define CISM_SNAP_OUT_OFS 8'h10
`define CISM_POL_OFS      8'h14
`define CISM_CHAT_OFS     8'h18
`define CISM_STAB_OFS     8'h1C
`define CISM_INV_OFS      8'h20

// control fields: view select, single-function code
`define CISM_CTRL_VIEW_LSB  0
`define CISM_CTRL_VIEW_MSB  1
`define CISM_CTRL_CODE_LSB  4
`define CISM_CTRL_CODE_MSB  8
// command fields
`define CISM_CMD_REPEAT_BIT 0
`define CISM_CMD_SINGLE_BIT 1
`define CISM_CMD_ABORT_BIT  2

// reset values: emergency stop input inverted (normally closed)
`define CISM_POL_RESET  17'h00001
`define CISM_CHAT_RESET 8'h04
`define CISM_STAB_RESET 8'h04
`define CISM_INV_RESET  8'h00

// filter time unit and clock
`define CISM_CLK_NS   4
`define CISM_TICK_NS  1000
`define CISM_TICK_CYC (`CISM_TICK_NS / `CISM_CLK_NS)

`endif

// ---- pkg/cism_pkg.sv ----
/*
 * Types of the control I/O state monitor.
 * Assumes: used as cism_pkg::name, never imported.
 */
package cism_pkg;
    // monitor view select
    typedef enum logic [1:0] {
        CISM_VIEW_RAW  = 2'h0,
        CISM_VIEW_FILT = 2'h1,
        CISM_VIEW_IFN  = 2'h2,
        CISM_VIEW_OFN  = 2'h3
    } cism_view_t;
    // monitor sequencer, one-hot
    typedef enum logic [1:0] {
        CISM_ST_PROMPT  = 2'b01,
        CISM_ST_REFRESH = 2'b10
    } cism_state_t;
endpackage

// ---- tb/cism_host.sv ----
/*
 * Host controller model: drives the discrete control inputs and the
 * output function conditions of the control I/O state monitor.
 * Assumes: the bench sets the wanted levels; contacts settle one
 * clock after the host changes them.
 */
`timescale 1ns/10ps
`default_nettype none

module cism_host (
    input  wire logic        clock,
    input  wire logic [16:0] pin_req,
    input  wire logic [9:0]  cond_req,
    output logic      [16:0] control_in_pin,
    output logic      [9:0]  out_func_cond
);
    // contacts and conditions follow the request on the next edge
    always_ff @(posedge clock) begin
        control_in_pin <= pin_req;
        out_func_cond  <= cond_req;
    end
endmodule

`default_nettype wire

// ---- tb/cism_top_bench.sv ----
/*
 * Self-checking bench of the control I/O state monitor: APB master,
 * host model on the pins, integer model of every monitor view.
 * Assumes: cism_top with default parameters, 250 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cism_top_bench;
    logic        clock   = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [16:0] control_in_pin;
    wire  [9:0]  out_func_cond;
    wire  [7:0]  control_out_pin;
    wire  [15:0] in_func_state;
    logic [16:0] pin_req  = 17'h00000;
    logic [9:0]  cond_req = 10'h000;
    logic [31:0] q;
    logic [31:0] sin;
    logic [31:0] sout;
    logic        err;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          p, c, f, pol, inv;

    // clock at 4 ns
    always #2 clock = ~clock;

    cism_top dut (
        .clock           (clock),
        .reset           (reset),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .control_in_pin  (control_in_pin),
        .out_func_cond   (out_func_cond),
        .control_out_pin (control_out_pin),
        .in_func_state   (in_func_state)
    );

    cism_host host (
        .clock          (clock),
        .pin_req        (pin_req),
        .cond_req       (cond_req),
        .control_in_pin (control_in_pin),
        .out_func_cond  (out_func_cond)
    );

    // one APB transfer: setup, access held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // select a view, start repeat readout, read both snapshots
    task automatic cap(input logic [31:0] ctrl);
        apb(1'b1, 8'h00, ctrl);
        apb(1'b1, 8'h04, 32'h00000001);
        apb(1'b0, 8'h0C, 32'h00000000);
        sin = q;
        apb(1'b0, 8'h10, 32'h00000000);
        sout = q;
    endtask

    // single-function capture, result in sin
    task automatic one(input logic [31:0] code);
        apb(1'b1, 8'h00, code << 4);
        apb(1'b1, 8'h04, 32'h00000002);
        apb(1'b0, 8'h0C, 32'h00000000);
        sin = q;
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog well past the expected run length
    initial begin
        #(4 * 30000);
        n_fail++;
        complete_run();
    end

    // main sequence
    initial begin
        q = $urandom(53);
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        // reset values of the settings
        apb(1'b0, 8'h14, 32'h00000000);
        chk(q, 32'h00000001);
        apb(1'b0, 8'h18, 32'h00000000);
        chk(q, 32'h00000004);
        apb(1'b0, 8'h1C, 32'h00000000);
        chk(q, 32'h00000004);
        apb(1'b0, 8'h20, 32'h00000000);
        chk(q, 32'h00000000);
        apb(1'b0, 8'h40, 32'h00000000);
        chk(q, 32'h00000000);
        chk(err, 32'h00000001);
        // shortest filters so changes pass quickly
        apb(1'b1, 8'h18, 32'h00000000);
        apb(1'b1, 8'h1C, 32'h00000000);
        for (int r = 0; r < 4; r++) begin
            p   = $urandom & 32'h0001FFFF;
            c   = $urandom & 32'h000003FF;
            pol = $urandom & 32'h0001FFFF;
            inv = $urandom & 32'h000000FF;
            if (r < 2) begin
                pol = pol | 1;
                p   = (p & 32'h0001FFFE) | r;
            end
            apb(1'b1, 8'h14, pol);
            apb(1'b1, 8'h20, inv);
            pin_req  <= p[16:0];
            cond_req <= c[9:0];
            repeat (600) @(posedge clock);
            f = p ^ pol;
            chk(in_func_state, f & 32'h0000FFFF);
            chk(control_out_pin, (c ^ inv) & 32'h000000FF);
            if (r < 2) begin
                chk(in_func_state[0], r == 0);
            end
            cap(32'h00000000);
            chk(sin, p);
            chk(sout, (c ^ inv) & 32'h000000FF);
            cap(32'h00000001);
            chk(sin, f);
            chk(sout, c & 32'h000000FF);
            cap(32'h00000002);
            chk(sin, f & 32'h0000FFFF);
            cap(32'h00000003);
            chk(sout, c);
            one(32'h00000005);
            chk(sin, (f >> 5) & 1);
            one(32'h00000010 + 3 * r);
            chk(sin, (c >> (3 * r)) & 1);
        end
        one(32'h0000001C);
        chk(sin, 32'h00000000);
        // long stability time: function view sees the change first
        apb(1'b1, 8'h1C, 32'h000000FF);
        cond_req <= ~c[9:0];
        repeat (4) @(posedge clock);
        cap(32'h00000003);
        chk(sout, ~c & 32'h000003FF);
        cap(32'h00000001);
        chk(sout, c & 32'h000000FF);
        // repeat readout refreshes until abort
        cap(32'h00000000);
        pin_req <= ~p[16:0];
        repeat (600) @(posedge clock);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk(q, ~p & 32'h0001FFFF);
        apb(1'b0, 8'h08, 32'h00000000);
        chk(q & 32'h00000001, 32'h00000001);
        apb(1'b1, 8'h04, 32'h00000004);
        apb(1'b0, 8'h08, 32'h00000000);
        chk(q & 32'h00000001, 32'h00000000);
        chk(q & 32'h00000002, 32'h00000002);
        pin_req <= p[16:0];
        repeat (600) @(posedge clock);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk(q, ~p & 32'h0001FFFF);
        complete_run();
    end
endmodule

`default_nettype wire
